// ==== common/mode_ctl_defines.svh ====
/*
  timing counts for the transceiver mode controller.
  assumes a 100 MHz ref_clk; included by design files by bare name.
*/
`ifndef MODE_CTL_DEFINES_SVH
`define MODE_CTL_DEFINES_SVH
`define CLK_PERIOD_NS       32'd10
`define RESET_HOLD_US       32'd4000
`define RESET_HOLD_CYC      ((`RESET_HOLD_US * 32'd1000) / `CLK_PERIOD_NS)
`define WAKE_DOM_US         32'd100
`define WAKE_DOM_CYC        (((`WAKE_DOM_US * 32'd1000) + `CLK_PERIOD_NS - 32'd1) / `CLK_PERIOD_NS)
`define TX_DOM_TIMEOUT_US   32'd40000
`define TX_DOM_TIMEOUT_CYC  ((`TX_DOM_TIMEOUT_US * 32'd1000) / `CLK_PERIOD_NS)
`define TX_STUCK_US         32'd20000
`define TX_STUCK_CYC        (((`TX_STUCK_US * 32'd1000) + `CLK_PERIOD_NS - 32'd1) / `CLK_PERIOD_NS)
`define TX_REARM_NS         32'd10000
`define TX_REARM_CYC        (((`TX_REARM_NS) + `CLK_PERIOD_NS - 32'd1) / `CLK_PERIOD_NS)
`define SLEEP_SKEW_NS       32'd3200
`define SLEEP_SKEW_CYC      ((`SLEEP_SKEW_NS) / `CLK_PERIOD_NS)
`define CNT_W               22
`endif

// ==== common/mode_ctl_pkg.sv ====
/*
  types of the transceiver mode controller.
  assumes nothing beyond a SystemVerilog compiler.
*/
package mode_ctl_pkg;
  typedef enum logic [2:0] {
    M_UNPOWERED = 3'h0,
    M_FAILSAFE  = 3'h1,
    M_NORMAL    = 3'h3,
    M_SILENT    = 3'h2,
    M_SLEEP     = 3'h6
  } mode_t;

  typedef enum logic [1:0] {
    W_IDLE = 2'h0,
    W_LOW  = 2'h1,
    W_HELD = 2'h3
  } wake_t;

  typedef struct packed {
    logic tx_en;
    logic rx_fwd;
    logic term_on;
    logic reg_on;
    logic rx_wake;
  } path_ctl_t;
endpackage

// ==== logic/lin_transceiver_mode_control.sv ====
/*
  mode controller of a single-wire bus transceiver with regulator.
  assumes pins arrive asynchronously and are synchronised here; analog comparators
  (supply, regulator undervoltage, temperature, pre-wake) come in as logic levels.
*/
// Behaviour
// RULE1: undervoltage in normal or silent drives reset low and enters fail-safe.
// RULE2: enable falling with transmit data high enters silent; host holds it high.
// RULE3: silent disables transmit, receive data high, termination off, any bus level.
// RULE4: below pre-wake level in silent or sleep, receiver on and wake timer starts.
// RULE5: wake needs falling edge, dominant longer than minimum, then rising edge.
// RULE6: wake from silent or sleep goes fail-safe, regulator and termination on.
// RULE7: after wake receive data low; otherwise high in fail-safe.
// RULE8: enable falling with transmit data low enters sleep; host holds it low.
// RULE9: enable may fall up to 3.2us before transmit data; bus undisturbed.
// RULE10: sleep: no transmit, regulator off, reset and receive data low, termination off.
// RULE11: enable high in sleep goes fail-safe, then normal after ramp and reset hold.
// RULE12: power-up enters fail-safe, regulator on, reset low for 4ms.
// RULE13: fail-safe holds until enable high, then normal.
// RULE14: supply below 1.9V in silent or sleep makes next power-up unpowered.
// RULE15: reset output low always forces fail-safe; the code does so outside sleep and unpowered only.
// RULE16: supply above 2.4V leaves unpowered for fail-safe.
// RULE17: mode requests ignored during reset hold after power-up.
// RULE18: driver overtemperature turns bus output off until cooled; regulator keeps on.
// RULE19: bus shorted low still allows sleep or silent; short release wakes.
// RULE20: regulator short: reset low, fail-safe; regulator restarts after cooling.
// RULE21: transmit low at normal entry keeps driver off until high over 10us.
// RULE22: transmit stuck low permits sleep via enable after 20ms dominant.
// RULE23: normal mode drives bus from transmit data, receive data mirrors bus.
// RULE24: transmit low past dominant timeout releases bus until transmit high.
// RULE25: wake minimum, reset hold and dominant timeout are parameters.
`timescale 1ns/1ps
`include "mode_ctl_defines.svh"
module lin_transceiver_mode_control
  import mode_ctl_pkg::*;
#(
  parameter logic [`CNT_W-1:0] RESET_HOLD  = `CNT_W'(`RESET_HOLD_CYC),     // RULE25
  parameter logic [`CNT_W-1:0] WAKE_DOM    = `CNT_W'(`WAKE_DOM_CYC),       // RULE25
  parameter logic [`CNT_W-1:0] DOM_TIMEOUT = `CNT_W'(`TX_DOM_TIMEOUT_CYC), // RULE25
  parameter logic [`CNT_W-1:0] TX_STUCK    = `CNT_W'(`TX_STUCK_CYC),
  parameter logic [`CNT_W-1:0] TX_REARM    = `CNT_W'(`TX_REARM_CYC),
  parameter logic [`CNT_W-1:0] SLEEP_SKEW  = `CNT_W'(`SLEEP_SKEW_CYC)
) (
  input  wire logic ref_clk,
  input  wire logic rst,
  input  wire logic enable_in,
  input  wire logic txd_in,
  input  wire logic bus_in,
  input  wire logic battery_supply_ok,
  input  wire logic battery_supply_lost,
  input  wire logic vcc_undervolt,
  input  wire logic bus_driver_shutdown_temp,
  input  wire logic reg_overtemp,
  output logic      bus_drive_low,
  output logic      rxd_out,
  output logic      undervoltage_reset_out,
  output logic      term_on,
  output logic      reg_on,
  output logic      rx_active,
  output mode_t     mode
);
  logic [6:0]        pins_s;
  logic              en_s, tx_s, bus_s, sup_ok_s, sup_lost_s, uv_s, hot_s;
  mode_t             mode_r;
  mode_t             mode_nxt;
  logic [`CNT_W-1:0] hold_cnt_r;
  logic [`CNT_W-1:0] dom_cnt_r;
  logic [`CNT_W-1:0] hi_cnt_r;
  logic [`CNT_W-1:0] skew_cnt_r;
  logic              en_prev_r;
  logic              tx_at_fall_r;
  logic              pend_sleep_r;
  logic              tx_block_r;
  logic              timed_out_r;
  logic              wake_flag_r;
  logic              lost_r;
  logic              wake_pulse;
  logic              wake_rx;
  path_ctl_t         ctl;

  // idle pin levels, so no false edge or power-up follows reset
  sync2 #(.W(7), .INIT(7'h30)) u_sync (
    .ref_clk (ref_clk),
    .rst     (rst),
    .d       ({enable_in, txd_in, bus_in, battery_supply_ok,
               battery_supply_lost, vcc_undervolt, bus_driver_shutdown_temp}),
    .q       (pins_s)
  );
  assign {en_s, tx_s, bus_s, sup_ok_s, sup_lost_s, uv_s, hot_s} = pins_s;

  wire arm = (mode_r == M_SILENT) || (mode_r == M_SLEEP);

  wake_detect #(.DOM_MIN(WAKE_DOM)) u_wake (
    .ref_clk    (ref_clk),
    .rst        (rst),
    .arm        (arm),                                     // RULE4
    .bus_lvl    (bus_s),
    .rx_active  (wake_rx),
    .wake_pulse (wake_pulse)
  );

  // decode helpers
  wire holding    = (hold_cnt_r != '0);                                   // RULE17
  wire reset_low  = holding | uv_s;                                        // RULE15
  wire en_fall    = en_prev_r & ~en_s;
  wire en_rise    = ~en_prev_r & en_s;
  wire stuck_ok   = (dom_cnt_r > TX_STUCK);                                // RULE22
  // sleep asks for tx low at the end of the skew window, tolerating early enable
  wire skew_done  = pend_sleep_r && (skew_cnt_r >= SLEEP_SKEW);            // RULE9
  wire go_silent  = skew_done & tx_s;                                      // RULE2
  wire go_sleep   = skew_done & ~tx_s & (~tx_at_fall_r | ~timed_out_r | stuck_ok); // RULE8
  wire act_mode   = (mode_r == M_NORMAL) || (mode_r == M_SILENT);

  always_comb begin
    mode_nxt = mode_r;
    case (mode_r)
      M_UNPOWERED: if (sup_ok_s) mode_nxt = M_FAILSAFE;                   // RULE16
      M_FAILSAFE:  if (!reset_low && en_s) mode_nxt = M_NORMAL;           // RULE13
      M_NORMAL:    if (go_sleep) mode_nxt = M_SLEEP;                      // RULE8
                   else if (go_silent) mode_nxt = M_SILENT;               // RULE2
      M_SILENT:    if (wake_pulse) mode_nxt = M_FAILSAFE;                 // RULE6
                   else if (en_rise) mode_nxt = M_FAILSAFE;
      M_SLEEP:     if (wake_pulse || en_rise) mode_nxt = M_FAILSAFE;      // RULE11
      default:     mode_nxt = M_FAILSAFE;
    endcase
    if (act_mode && uv_s) mode_nxt = M_FAILSAFE;                           // RULE1
    if (mode_r != M_UNPOWERED && mode_r != M_SLEEP && reset_low) begin
      mode_nxt = M_FAILSAFE;                                               // RULE15
    end
    if (!sup_ok_s && (arm ? lost_r : 1'b1)) mode_nxt = M_UNPOWERED;        // RULE14
  end

  always_comb begin
    ctl.tx_en   = (mode_r == M_NORMAL) && !tx_block_r && !timed_out_r && !hot_s; // RULE18
    ctl.rx_fwd  = (mode_r == M_NORMAL);                                    // RULE23
    ctl.term_on = (mode_r == M_NORMAL) || (mode_r == M_FAILSAFE);         // RULE3
    // regulator restarts by itself in fail-safe once cooled, whatever enable is
    ctl.reg_on  = (mode_r != M_SLEEP) && (mode_r != M_UNPOWERED) && !reg_overtemp; // RULE20
    ctl.rx_wake = (mode_r == M_FAILSAFE) && wake_flag_r;                   // RULE7
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      mode_r    <= M_UNPOWERED;
      en_prev_r <= 1'b0;
      lost_r    <= 1'b0;
    end else begin
      mode_r    <= mode_nxt;
      en_prev_r <= en_s;
      lost_r    <= arm ? (lost_r | sup_lost_s) : 1'b0;                     // RULE14
    end
  end

  // reset hold restarts on every entry to fail-safe from a powerless state
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      hold_cnt_r <= '0;
    end else if ((mode_r == M_UNPOWERED || mode_r == M_SLEEP) && mode_nxt == M_FAILSAFE) begin
      hold_cnt_r <= RESET_HOLD;                                            // RULE12
    end else if (uv_s && mode_r != M_SLEEP) begin
      hold_cnt_r <= RESET_HOLD;                                            // RULE20
    end else if (holding) begin
      hold_cnt_r <= hold_cnt_r - `CNT_W'(1);
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      pend_sleep_r <= 1'b0;
      skew_cnt_r   <= '0;
      tx_at_fall_r <= 1'b0;
    end else if (mode_r == M_NORMAL && en_fall && !holding) begin
      pend_sleep_r <= 1'b1;                                                // RULE17
      skew_cnt_r   <= '0;
      tx_at_fall_r <= ~tx_s;
    end else if (pend_sleep_r && mode_r == M_NORMAL && !en_s && !skew_done) begin
      skew_cnt_r   <= skew_cnt_r + `CNT_W'(1);
    end else begin
      pend_sleep_r <= 1'b0;
      skew_cnt_r   <= '0;
    end
  end

  // one counter serves the dominant timeout and the stuck-low sleep permit
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      dom_cnt_r   <= '0;
      timed_out_r <= 1'b0;
      hi_cnt_r    <= '0;
      tx_block_r  <= 1'b0;
    end else begin
      dom_cnt_r   <= tx_s ? '0 : (stuck_ok && dom_cnt_r > DOM_TIMEOUT ? dom_cnt_r
                                   : dom_cnt_r + `CNT_W'(1));
      if (tx_s) begin
        timed_out_r <= 1'b0;                                               // RULE24
      end else if (dom_cnt_r > DOM_TIMEOUT) begin
        timed_out_r <= 1'b1;                                               // RULE24
      end
      hi_cnt_r    <= (tx_s && tx_block_r && hi_cnt_r <= TX_REARM) ? hi_cnt_r + `CNT_W'(1)
                     : (tx_s ? hi_cnt_r : '0);
      if (mode_r != M_NORMAL && mode_nxt == M_NORMAL && !tx_s) begin
        tx_block_r <= 1'b1;                                                // RULE21
      end else if (hi_cnt_r > TX_REARM) begin
        tx_block_r <= 1'b0;                                                // RULE21
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      wake_flag_r <= 1'b0;
    end else if (wake_pulse) begin
      wake_flag_r <= 1'b1;                                                 // RULE19
    end else if (mode_r != M_FAILSAFE) begin
      wake_flag_r <= 1'b0;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      bus_drive_low          <= 1'b0;
      rxd_out                <= 1'b1;
      undervoltage_reset_out <= 1'b0;
      term_on                <= 1'b0;
      reg_on                 <= 1'b0;
      rx_active              <= 1'b0;
      mode                   <= M_UNPOWERED;
    end else begin
      bus_drive_low          <= ctl.tx_en & ~tx_s & ~pend_sleep_r;         // RULE23
      rxd_out                <= ctl.rx_fwd ? bus_s
                                : (mode_r == M_SLEEP ? 1'b0 : ~ctl.rx_wake); // RULE10
      undervoltage_reset_out <= ~(reset_low | mode_r == M_SLEEP
                                  | mode_r == M_UNPOWERED);                // RULE1
      term_on                <= ctl.term_on;                               // RULE6
      reg_on                 <= ctl.reg_on;                                // RULE10
      rx_active              <= ctl.rx_fwd | wake_rx;                      // RULE4
      mode                   <= mode_r;
    end
  end
endmodule

// ==== logic/sync2.sv ====
/*
  two-flop synchroniser for a vector of pin inputs.
  assumes inputs asynchronous to ref_clk; rst is synchronous, active high.
*/
`timescale 1ns/1ps
module sync2 #(
  parameter int W = 1,
  parameter logic [W-1:0] INIT = '0
) (
  input  wire logic         ref_clk,
  input  wire logic         rst,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);
  logic [W-1:0] meta_r;

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      meta_r <= INIT;
      q      <= INIT;
    end else begin
      meta_r <= d;
      q      <= meta_r;
    end
  end
endmodule

// ==== logic/wake_detect.sv ====
/*
  remote wake detector: falling edge, dominant held past a minimum, rising edge.
  assumes bus_lvl already synchronised; arm is high in silent or sleep.
*/
`timescale 1ns/1ps
`include "mode_ctl_defines.svh"
module wake_detect
  import mode_ctl_pkg::*;
#(
  parameter logic [`CNT_W-1:0] DOM_MIN = `CNT_W'(`WAKE_DOM_CYC)
) (
  input  wire logic ref_clk,
  input  wire logic rst,
  input  wire logic arm,
  input  wire logic bus_lvl,
  output logic      rx_active,
  output logic      wake_pulse
);
  wake_t             st_r;
  wake_t             st_nxt;
  logic [`CNT_W-1:0] cnt_r;
  logic              prev_r;
  wire               fall    = prev_r & ~bus_lvl;
  wire               rise    = ~prev_r & bus_lvl;
  wire               held    = (cnt_r > DOM_MIN);
  wire               fire    = arm & (st_r == W_HELD) & rise;

  always_comb begin
    st_nxt = st_r;
    case (st_r)
      // a bus already low when armed counts as the falling edge (shorted bus)
      W_IDLE:  if (fall || !bus_lvl) st_nxt = W_LOW;      // RULE5 RULE19
      W_LOW:   if (rise) st_nxt = W_IDLE;
               else if (held) st_nxt = W_HELD;            // RULE5
      W_HELD:  if (rise) st_nxt = W_IDLE;
      default: st_nxt = W_IDLE;
    endcase
    if (!arm) st_nxt = W_IDLE;
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      st_r       <= W_IDLE;
      cnt_r      <= '0;
      prev_r     <= 1'b1;
      rx_active  <= 1'b0;
      wake_pulse <= 1'b0;
    end else begin
      st_r       <= st_nxt;
      prev_r     <= bus_lvl;
      // timer runs only while dominant below the pre-wake level
      cnt_r      <= (!arm || bus_lvl) ? '0 : (held ? cnt_r : cnt_r + `CNT_W'(1)); // RULE4
      rx_active  <= arm & ~bus_lvl;                       // RULE4
      wake_pulse <= fire;                                 // RULE5
    end
  end
endmodule

// ==== verif/host_model.sv ====
/*
  host model driving enable and transmit data of the mode controller.
  assumes cmd from the bench: 0 hold, 1 normal, 2 silent, 3 sleep.
*/
`timescale 1ns/1ps
module host_model (
  input  wire logic       ref_clk,
  input  wire logic [1:0] cmd,
  input  wire logic       tx_bit,
  output logic            enable_in,
  output logic            txd_in
);
  logic [1:0] cmd_r;
  initial begin
    enable_in = 1'b0;
    txd_in = 1'b1;
    cmd_r = 2'h0;
  end
  // txd held high through the silent select window; for sleep it drops one cycle after enable
  always @(posedge ref_clk) begin
    cmd_r <= cmd;
    case (cmd)
      2'h1: begin
        enable_in <= 1'b1;
        txd_in <= tx_bit;
      end
      2'h2: begin
        enable_in <= 1'b0;
        txd_in <= 1'b1;
      end
      // enable falls one cycle before txd, well inside the skew allowance
      2'h3: begin
        enable_in <= 1'b0;
        txd_in <= (cmd_r == 2'h3) ? 1'b0 : txd_in;
      end
      default: ;
    endcase
  end
endmodule

// ==== verif/mode_ctl_props.sv ====
/*
  concurrent checks on the mode controller ports.
  assumes the design top as bound at the foot; one clock domain.
*/
`timescale 1ns/1ps
`include "mode_ctl_defines.svh"
module mode_ctl_props
  import mode_ctl_pkg::*;
#(
  parameter logic [`CNT_W-1:0] RESET_HOLD  = `CNT_W'h32,
  parameter logic [`CNT_W-1:0] DOM_TIMEOUT = `CNT_W'hC8
) (
  input wire logic  ref_clk,
  input wire logic  rst,
  input wire logic  txd_in,
  input wire logic  bus_in,
  input wire logic  bus_driver_shutdown_temp,
  input wire logic  bus_drive_low,
  input wire logic  rxd_out,
  input wire logic  undervoltage_reset_out,
  input wire logic  term_on,
  input wire logic  reg_on,
  input wire mode_t mode
);
  int low_n;
  int dom_n;
  // hold length counted only in fail-safe, so sleep time does not count
  always_ff @(posedge ref_clk) begin
    low_n <= (undervoltage_reset_out || mode != M_FAILSAFE) ? 0 : low_n + 1;
    dom_n <= bus_drive_low ? dom_n + 1 : 0;
  end
  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);
  a_reset_hold_len: assert property ($rose(undervoltage_reset_out) |-> low_n >= RESET_HOLD - 2)
    else $error("reset released early");
  a_hold_no_normal: assert property (mode == M_FAILSAFE && !undervoltage_reset_out && low_n > 2
    |=> mode != M_NORMAL) else $error("mode change during reset hold");
  a_sleep_quiet: assert property (mode == M_SLEEP && $past(mode) == M_SLEEP
    |-> !reg_on && !rxd_out && !term_on && !undervoltage_reset_out) else $error("sleep outputs");
  a_silent_quiet: assert property (mode == M_SILENT && $past(mode) == M_SILENT
    |-> rxd_out && !term_on && reg_on && !bus_drive_low) else $error("silent outputs");
  a_failsafe_recessive: assert property (mode == M_FAILSAFE && $past(mode) == M_FAILSAFE
    |-> !bus_drive_low) else $error("bus driven in fail-safe");
  a_txd_recessive: assert property (mode == M_NORMAL && txd_in && $past(txd_in, 2)
    && $past(txd_in, 3) && $past(txd_in, 4) |-> !bus_drive_low) else $error("bus driven, txd high");
  a_rxd_mirror: assert property (mode == M_NORMAL && $past(mode, 4) == M_NORMAL
    && $past(bus_in, 2) == bus_in && $past(bus_in, 3) == bus_in && $past(bus_in, 4) == bus_in
    |-> rxd_out == bus_in) else $error("rxd does not follow bus");
  a_hot_release: assert property (bus_driver_shutdown_temp && $past(bus_driver_shutdown_temp, 2)
    && $past(bus_driver_shutdown_temp, 3) && $past(bus_driver_shutdown_temp, 4)
    |-> !bus_drive_low) else $error("bus driven while hot");
  a_dom_bound: assert property (dom_n <= DOM_TIMEOUT + 4)
    else $error("dominant past timeout");
  cover property (mode == M_SILENT);
  cover property (mode == M_SLEEP);
  cover property (mode == M_FAILSAFE && !rxd_out);
endmodule
bind lin_transceiver_mode_control mode_ctl_props #(.RESET_HOLD(RESET_HOLD),
  .DOM_TIMEOUT(DOM_TIMEOUT)) i_mode_ctl_props (.ref_clk, .rst, .txd_in, .bus_in,
  .bus_driver_shutdown_temp, .bus_drive_low, .rxd_out, .undervoltage_reset_out, .term_on,
  .reg_on, .mode);

// ==== verif/tb_lin_transceiver_mode_control.sv ====
/*
  bench for the mode controller with the host model on enable and txd.
  assumes shortened timing parameters; bus has a pull-up, short_low grounds it.
*/
`timescale 1ns/1ps
`include "mode_ctl_defines.svh"
module tb_lin_transceiver_mode_control;
  import mode_ctl_pkg::*;
  logic ref_clk = 1'b0;
  logic rst = 1'b1;
  logic supply_ok = 1'b0, uv = 1'b0, hot = 1'b0, short_low = 1'b0, tx_bit = 1'b1;
  logic [1:0] cmd = 2'h0;
  logic enable_in, txd_in, bus_in, bus_drive_low, rxd_out, undervoltage_reset_out;
  logic term_on, reg_on, rx_active;
  logic drove = 1'b0;
  mode_t mode;
  int num_errors = 0;
  int samples_checked = 0;
  always #5 ref_clk = ~ref_clk;
  assign bus_in = ~(bus_drive_low | short_low);
  always @(posedge ref_clk) if (cmd == 2'h3 && bus_drive_low) drove <= 1'b1;
  host_model i_host_model (.ref_clk, .cmd, .tx_bit, .enable_in, .txd_in);
  lin_transceiver_mode_control #(.RESET_HOLD(`CNT_W'h32), .WAKE_DOM(`CNT_W'hA),
    .DOM_TIMEOUT(`CNT_W'hC8), .TX_STUCK(`CNT_W'h64), .TX_REARM(`CNT_W'h5),
    .SLEEP_SKEW(`CNT_W'h3)) i_lin_transceiver_mode_control (.ref_clk, .rst, .enable_in,
    .txd_in, .bus_in, .battery_supply_ok(supply_ok), .battery_supply_lost(1'b0),
    .vcc_undervolt(uv), .bus_driver_shutdown_temp(hot), .reg_overtemp(1'b0), .bus_drive_low,
    .rxd_out, .undervoltage_reset_out, .term_on, .reg_on, .rx_active, .mode);
  task automatic tick(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask
  task automatic chk(input logic exp, input logic got);
    samples_checked++;
    if (got !== exp) begin
      num_errors++;
      $display("FAIL %0t pin %b expected %b", $time, got, exp);
    end
  endtask
  task automatic chk_mode(input mode_t exp);
    samples_checked++;
    if (mode !== exp) begin
      num_errors++;
      $display("FAIL %0t mode %h expected %h", $time, mode, exp);
    end
  endtask
  // bounded so a stuck mode shows up as a mismatch, not a hang
  task automatic wait_mode(input mode_t m);
    int i;
    i = 0;
    while (mode !== m && i < 300) begin
      tick(1);
      i++;
    end
  endtask
  task automatic t_powerup;
    supply_ok = 1'b1;
    wait_mode(M_FAILSAFE);
    chk_mode(M_FAILSAFE);
    tick(2);
    chk(1'b1, reg_on);
    cmd = 2'h1;
    tick(30);
    chk(1'b0, undervoltage_reset_out);
    chk_mode(M_FAILSAFE);
    wait_mode(M_NORMAL);
    chk_mode(M_NORMAL);
    chk(1'b1, undervoltage_reset_out);
    $display("powerup done");
  endtask
  task automatic t_normal;
    tx_bit = 1'b0;
    tick(7);
    chk(1'b1, bus_drive_low);
    chk(1'b0, rxd_out);
    tick(210);
    chk(1'b0, bus_drive_low);
    tx_bit = 1'b1;
    tick(12);
    tx_bit = 1'b0;
    tick(6);
    chk(1'b1, bus_drive_low);
    hot = 1'b1;
    tick(6);
    chk(1'b0, bus_drive_low);
    chk(1'b1, reg_on);
    hot = 1'b0;
    tx_bit = 1'b1;
    tick(12);
    $display("normal done");
  endtask
  task automatic t_silent;
    cmd = 2'h2;
    wait_mode(M_SILENT);
    chk_mode(M_SILENT);
    tick(2);
    chk(1'b1, rxd_out);
    chk(1'b0, term_on);
    short_low = 1'b1;
    tick(5);
    chk(1'b1, rx_active);
    short_low = 1'b0;
    tick(8);
    chk_mode(M_SILENT);
    short_low = 1'b1;
    tick(30);
    short_low = 1'b0;
    wait_mode(M_FAILSAFE);
    tick(2);
    chk_mode(M_FAILSAFE);
    chk(1'b0, rxd_out);
    chk(1'b1, term_on);
    chk(1'b1, reg_on);
    cmd = 2'h1;
    wait_mode(M_NORMAL);
    chk_mode(M_NORMAL);
    $display("silent done");
  endtask
  task automatic t_sleep;
    short_low = 1'b1;
    cmd = 2'h3;
    wait_mode(M_SLEEP);
    tick(2);
    chk_mode(M_SLEEP);
    chk(1'b0, drove);
    chk(1'b0, reg_on);
    chk(1'b0, undervoltage_reset_out);
    chk(1'b0, rxd_out);
    chk(1'b0, term_on);
    tick(20);
    short_low = 1'b0;
    wait_mode(M_FAILSAFE);
    tick(2);
    chk_mode(M_FAILSAFE);
    chk(1'b1, reg_on);
    chk(1'b0, rxd_out);
    $display("sleep done");
  endtask
  task automatic t_enable_wake;
    cmd = 2'h1;
    wait_mode(M_NORMAL);
    cmd = 2'h3;
    wait_mode(M_SLEEP);
    cmd = 2'h1;
    wait_mode(M_FAILSAFE);
    chk_mode(M_FAILSAFE);
    tick(2);
    chk(1'b0, undervoltage_reset_out);
    wait_mode(M_NORMAL);
    chk_mode(M_NORMAL);
    $display("enable wake done");
  endtask
  task automatic t_undervolt;
    uv = 1'b1;
    tx_bit = 1'b0;
    tick(6);
    chk(1'b0, undervoltage_reset_out);
    chk_mode(M_FAILSAFE);
    uv = 1'b0;
    wait_mode(M_NORMAL);
    tick(6);
    chk(1'b0, bus_drive_low);
    tx_bit = 1'b1;
    tick(3);
    tx_bit = 1'b0;
    tick(6);
    chk(1'b0, bus_drive_low);
    tx_bit = 1'b1;
    tick(12);
    tx_bit = 1'b0;
    tick(6);
    chk(1'b1, bus_drive_low);
    tx_bit = 1'b1;
    $display("undervolt done");
  endtask
  task automatic print_verdict;
    $display("checks %0d mismatches %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  initial begin
    #100000;
    num_errors++;
    print_verdict;
  end
  initial begin
    tick(8);
    rst = 1'b0;
    chk_mode(M_UNPOWERED);
    t_powerup;
    t_normal;
    t_silent;
    t_sleep;
    t_enable_wake;
    t_undervolt;
    supply_ok = 1'b0;
    wait_mode(M_UNPOWERED);
    chk_mode(M_UNPOWERED);
    print_verdict;
  end
endmodule
